// file: inc/imw_pkg.sv
// Shared constants and carrier types for the stillness and motion warning block.
// Assumes a 20 MHz system clock and byte-wide register access from the serial front end.
package imw_pkg;

    // ==================================================================
    // Register offsets
    localparam logic [7:0] ADDR_STILL_Z_LOW = 8'h2F;
    localparam logic [7:0] ADDR_STILL_TIMER_HIGH = 8'h30;
    localparam logic [7:0] ADDR_STILL_TIMER_LOW = 8'h31;
    localparam logic [7:0] ADDR_WARN_X_HIGH = 8'h32;
    localparam logic [7:0] ADDR_WARN_X_LOW = 8'h33;
    localparam logic [7:0] ADDR_WARN_Y_HIGH = 8'h34;
    localparam logic [7:0] ADDR_WARN_Y_LOW = 8'h35;

    // ==================================================================
    // Field positions and reset values
    localparam int THR_LSB_POS = 5;
    localparam int AXIS_EN_POS = 0;
    localparam int REF_SEL_POS = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ==================================================================
    // Time scale of one stillness code
    localparam real CLK_FREQ_KHZ = 20000.0;
    localparam real STILL_CODE_SLOW_MS = 32.5;
    localparam real STILL_CODE_FAST_MS = 16.25;
    localparam int STILL_CODE_SLOW_CYC = int'(STILL_CODE_SLOW_MS * CLK_FREQ_KHZ);
    localparam int STILL_CODE_FAST_CYC = int'(STILL_CODE_FAST_MS * CLK_FREQ_KHZ);

    // ==================================================================
    // Carrier types
    typedef struct packed {
        logic valid;
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } imw_sample_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } imw_reg_req_t;

    typedef struct packed {
        logic [10:0] x_still_thr;
        logic x_still_en;
        logic [10:0] y_still_thr;
        logic y_still_en;
        logic [7:0] z_still_thr_high;
        logic [10:0] z_warn_thr;
        logic z_warn_en;
    } imw_ext_cfg_t;

endpackage

// file: rtl/imw_axis_cmp.sv
// One axis comparator: magnitude of a sample, absolute or against a reference.
// Assumes a two's complement 12-bit sample and an unsigned 11-bit threshold.
`timescale 1ns/1ps
module imw_axis_cmp (
    input wire logic signed [11:0] i_sample,
    input wire logic signed [11:0] i_ref,
    input wire logic i_use_ref,
    input wire logic [10:0] i_thr,
    output logic o_over,
    output logic o_at_or_over
);
    import imw_pkg::*;

    logic signed [12:0] diff;
    logic [11:0] mag;

    // A 13-bit difference keeps the full span, so the magnitude never wraps.
    always_comb begin
        diff = i_use_ref ? (13'(i_sample) - 13'(i_ref)) : 13'(i_sample);
        mag = diff[12] ? 12'(-diff) : diff[11:0];
        o_over = mag > {1'b0, i_thr};
        o_at_or_over = mag >= {1'b0, i_thr};
    end

endmodule

// file: rtl/imw_still_timer.sv
// Stillness timer: a wall-clock prescaler that ticks once per code and a
// saturating 16-bit code counter.
// Assumes the caller restarts it on every sample that breaks stillness.
`timescale 1ns/1ps
module imw_still_timer #(
    parameter int P_CODE_CYC_SLOW = imw_pkg::STILL_CODE_SLOW_CYC,
    parameter int P_CODE_CYC_FAST = imw_pkg::STILL_CODE_FAST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic i_fast,
    input wire logic [15:0] i_target,
    output logic [15:0] o_count,
    output logic o_done
);
    import imw_pkg::*;

    logic [19:0] pre_ff;
    logic [15:0] count_ff;
    logic [19:0] pre_last;
    logic tick;

    assign pre_last = i_fast ? 20'(P_CODE_CYC_FAST - 1) : 20'(P_CODE_CYC_SLOW - 1);
    assign tick = (pre_ff >= pre_last);

    // ==================================================================
    // Prescaler
    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart || tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 20'h00001;
        end
    end

    // ==================================================================
    // Code counter; saturating so a long quiet spell never wraps to zero.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart) begin
            count_ff <= '0;
        end else if (tick && count_ff != COUNT_MAX) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    assign o_count = count_ff;
    assign o_done = (count_ff >= i_target);

endmodule

// file: rtl/imw_detect.sv
// Stillness detection and second motion detector for the x, y and z axes, with
// their byte-wide configuration registers.
// Assumes samples arrive as a one-cycle valid strobe, register access comes
// from the serial front end as one-cycle strobes, and the x/y stillness and
// z warning settings are supplied by neighbouring register slices.
`timescale 1ns/1ps
module imw_detect #(
    parameter int P_CODE_CYC_SLOW = imw_pkg::STILL_CODE_SLOW_CYC,
    parameter int P_CODE_CYC_FAST = imw_pkg::STILL_CODE_FAST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire imw_pkg::imw_reg_req_t i_reg,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire imw_pkg::imw_sample_t i_sample,
    input wire logic i_rate_fast,
    input wire imw_pkg::imw_ext_cfg_t i_ext_cfg,
    output logic o_still_pulse,
    output logic o_still_active,
    output logic [15:0] o_still_duration_count,
    output logic o_warn_pulse,
    output logic [2:0] o_warn_axes
);
    import imw_pkg::*;

    // ==================================================================
    // Stillness state
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_COUNT = 2'b01,
        ST_STILL = 2'b10
    } imw_still_st_t;

    // ==================================================================
    // Register storage; only the defined bits are kept, reserved bits read zero.
    logic [2:0] z_still_thr_low_ff;
    logic z_still_axis_enable_ff;
    logic [7:0] still_value_high_ff;
    logic [7:0] still_value_low_ff;
    logic [10:0] x_warning_threshold_ff;
    logic warning_referenced_select_ff;
    logic x_warning_axis_enable_ff;
    logic [10:0] y_warning_threshold_ff;
    logic y_warning_axis_enable_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [7:0] nxt_rdata;
    logic timer_write;
    logic ref_write;

    always_comb begin
        timer_write = i_reg.wr &&
            (i_reg.addr == ADDR_STILL_TIMER_HIGH || i_reg.addr == ADDR_STILL_TIMER_LOW);
        ref_write = i_reg.wr && i_reg.addr == ADDR_WARN_X_LOW;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            z_still_thr_low_ff <= REG_RESET[7:5];
            z_still_axis_enable_ff <= REG_RESET[0];
        end else if (i_reg.wr && i_reg.addr == ADDR_STILL_Z_LOW) begin
            z_still_thr_low_ff <= i_reg.wdata[THR_LSB_POS +: 3];
            z_still_axis_enable_ff <= i_reg.wdata[AXIS_EN_POS];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            still_value_high_ff <= REG_RESET;
            still_value_low_ff <= REG_RESET;
        end else if (i_reg.wr && i_reg.addr == ADDR_STILL_TIMER_HIGH) begin
            still_value_high_ff <= i_reg.wdata;
        end else if (i_reg.wr && i_reg.addr == ADDR_STILL_TIMER_LOW) begin
            still_value_low_ff <= i_reg.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            x_warning_threshold_ff <= {REG_RESET, REG_RESET[2:0]};
            warning_referenced_select_ff <= REG_RESET[1];
            x_warning_axis_enable_ff <= REG_RESET[0];
        end else if (i_reg.wr && i_reg.addr == ADDR_WARN_X_HIGH) begin
            x_warning_threshold_ff[10:3] <= i_reg.wdata;
        end else if (i_reg.wr && i_reg.addr == ADDR_WARN_X_LOW) begin
            x_warning_threshold_ff[2:0] <= i_reg.wdata[THR_LSB_POS +: 3];
            warning_referenced_select_ff <= i_reg.wdata[REF_SEL_POS];
            x_warning_axis_enable_ff <= i_reg.wdata[AXIS_EN_POS];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            y_warning_threshold_ff <= {REG_RESET, REG_RESET[2:0]};
            y_warning_axis_enable_ff <= REG_RESET[0];
        end else if (i_reg.wr && i_reg.addr == ADDR_WARN_Y_HIGH) begin
            y_warning_threshold_ff[10:3] <= i_reg.wdata;
        end else if (i_reg.wr && i_reg.addr == ADDR_WARN_Y_LOW) begin
            y_warning_threshold_ff[2:0] <= i_reg.wdata[THR_LSB_POS +: 3];
            y_warning_axis_enable_ff <= i_reg.wdata[AXIS_EN_POS];
        end
    end

    // ==================================================================
    // Read path; an unmapped offset answers zero rather than stalling the front end.
    always_comb begin
        nxt_rdata = RDATA_UNMAPPED;
        if (i_reg.addr == ADDR_STILL_Z_LOW) begin
            nxt_rdata = {z_still_thr_low_ff, 4'h0, z_still_axis_enable_ff};
        end else if (i_reg.addr == ADDR_STILL_TIMER_HIGH) begin
            nxt_rdata = still_value_high_ff;
        end else if (i_reg.addr == ADDR_STILL_TIMER_LOW) begin
            nxt_rdata = still_value_low_ff;
        end else if (i_reg.addr == ADDR_WARN_X_HIGH) begin
            nxt_rdata = x_warning_threshold_ff[10:3];
        end else if (i_reg.addr == ADDR_WARN_X_LOW) begin
            nxt_rdata = {x_warning_threshold_ff[2:0], 3'h0,
                warning_referenced_select_ff, x_warning_axis_enable_ff};
        end else if (i_reg.addr == ADDR_WARN_Y_HIGH) begin
            nxt_rdata = y_warning_threshold_ff[10:3];
        end else if (i_reg.addr == ADDR_WARN_Y_LOW) begin
            nxt_rdata = {y_warning_threshold_ff[2:0], 4'h0, y_warning_axis_enable_ff};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= REG_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_reg.rd;
            if (i_reg.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;

    // ==================================================================
    // Assembled settings per axis, index 0 = x, 1 = y, 2 = z.
    logic [15:0] still_duration_value;
    logic [2:0][10:0] still_thr;
    logic [2:0] still_en;
    logic [2:0][10:0] warn_thr;
    logic [2:0] warn_en;
    logic [2:0][11:0] axis_sample;
    logic [2:0][11:0] axis_ref;
    logic [2:0] still_hit;
    logic [2:0] warn_over;

    always_comb begin
        still_duration_value = {still_value_high_ff, still_value_low_ff};
        still_thr[0] = i_ext_cfg.x_still_thr;
        still_thr[1] = i_ext_cfg.y_still_thr;
        still_thr[2] = {i_ext_cfg.z_still_thr_high, z_still_thr_low_ff};
        still_en = {z_still_axis_enable_ff, i_ext_cfg.y_still_en, i_ext_cfg.x_still_en};
        // Thresholds stay in raw codes; 200 mg per code matches the sample scale.
        warn_thr[0] = x_warning_threshold_ff;
        warn_thr[1] = y_warning_threshold_ff;
        warn_thr[2] = i_ext_cfg.z_warn_thr;
        warn_en = {i_ext_cfg.z_warn_en, y_warning_axis_enable_ff, x_warning_axis_enable_ff};
        axis_sample[0] = i_sample.x;
        axis_sample[1] = i_sample.y;
        axis_sample[2] = i_sample.z;
    end

    // ==================================================================
    // Reference for referenced warning processing. It is re-armed by a write
    // to the select, and after each warning, so the next sample becomes the
    // new baseline. No warning is raised while the baseline is missing.
    logic [2:0][11:0] ref_ff;
    logic ref_armed_ff;
    logic warn_any;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_armed_ff <= 1'b1;
        end else if (ref_write || (i_sample.valid && warn_any)) begin
            ref_armed_ff <= 1'b1;
        end else if (i_sample.valid) begin
            ref_armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_ff <= '0;
        end else if (i_sample.valid && (ref_armed_ff || warn_any)) begin
            ref_ff <= axis_sample;
        end
    end

    assign axis_ref = ref_ff;

    // ==================================================================
    // Per-axis comparators: one for stillness (absolute), one for warning.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            logic still_ge;
            logic warn_gt;
            imw_axis_cmp u_still_cmp (
                .i_sample(axis_sample[gi]),
                .i_ref(axis_ref[gi]),
                .i_use_ref(1'b0),
                .i_thr(still_thr[gi]),
                .o_over(),
                .o_at_or_over(still_ge)
            );
            imw_axis_cmp u_warn_cmp (
                .i_sample(axis_sample[gi]),
                .i_ref(axis_ref[gi]),
                .i_use_ref(warning_referenced_select_ff),
                .i_thr(warn_thr[gi]),
                .o_over(warn_gt),
                .o_at_or_over()
            );
            assign still_hit[gi] = still_en[gi] && still_ge;
            assign warn_over[gi] = warn_en[gi] && warn_gt;
        end
    endgenerate

    assign warn_any = (|warn_over) && !(warning_referenced_select_ff && ref_armed_ff);

    // ==================================================================
    // Motion warning outputs, registered per sample.
    logic warn_pulse_ff;
    logic [2:0] warn_axes_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            warn_pulse_ff <= 1'b0;
            warn_axes_ff <= '0;
        end else begin
            warn_pulse_ff <= i_sample.valid && warn_any;
            if (i_sample.valid) begin
                warn_axes_ff <= warn_any ? warn_over : 3'h0;
            end
        end
    end

    assign o_warn_pulse = warn_pulse_ff;
    assign o_warn_axes = warn_axes_ff;

    // ==================================================================
    // Stillness timer. It runs on wall time between samples, so the
    // duration does not depend on how many samples land in one code.
    logic timer_restart;
    logic timer_done;
    logic [15:0] timer_count;
    logic any_still_hit;

    assign any_still_hit = |still_hit;
    // A new duration value starts a fresh measurement.
    assign timer_restart = (i_sample.valid && any_still_hit) || timer_write;

    imw_still_timer #(
        .P_CODE_CYC_SLOW(P_CODE_CYC_SLOW),
        .P_CODE_CYC_FAST(P_CODE_CYC_FAST)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(timer_restart),
        .i_fast(i_rate_fast),
        .i_target(still_duration_value),
        .o_count(timer_count),
        .o_done(timer_done)
    );

    assign o_still_duration_count = timer_count;

    // ==================================================================
    // Stillness state machine. The event is declared on a quiet sample once
    // the full programmed time has passed, never on the timer tick alone.
    imw_still_st_t state_ff;
    imw_still_st_t nxt_state;
    logic still_pulse_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_WAIT: begin
                if (i_sample.valid) begin
                    nxt_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (i_sample.valid && !any_still_hit && timer_done && !timer_write) begin
                    nxt_state = ST_STILL;
                end
            end
            ST_STILL: begin
                if (timer_write || (i_sample.valid && any_still_hit)) begin
                    nxt_state = ST_COUNT;
                end
            end
            default: begin
                nxt_state = ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ST_WAIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            still_pulse_ff <= 1'b0;
        end else begin
            still_pulse_ff <= (state_ff == ST_COUNT) && (nxt_state == ST_STILL);
        end
    end

    assign o_still_pulse = still_pulse_ff;
    assign o_still_active = (state_ff == ST_STILL);

endmodule

// file: tb/imw_host.sv
// Host model: issues byte writes and reads on the detector's register strobe port.
// Assumes the detector's clock and one access at a time.
`timescale 1ns/1ps
module imw_host (
    input wire logic i_clk,
    output imw_pkg::imw_reg_req_t o_reg,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    import imw_pkg::*;
    // ==================================================================
    // Access tasks
    initial begin
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        // Released lines show the inverse, so a stale address is never read as a live one.
        o_reg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        o_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        o_reg <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule

// file: tb/imw_detect_props.sv
// Concurrent checks on the ports of the stillness and motion warning detector.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module imw_detect_props #(
    parameter int P_CODE_CYC_SLOW = 8,
    parameter int P_CODE_CYC_FAST = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire imw_pkg::imw_reg_req_t i_reg,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire imw_pkg::imw_sample_t i_sample,
    input wire logic o_still_pulse,
    input wire logic o_still_active,
    input wire logic [15:0] o_still_duration_count,
    input wire logic o_warn_pulse,
    input wire logic [2:0] o_warn_axes
);
    import imw_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==================================================================
    // Assertions
    read_answer_a: assert property (i_reg.rd |=> o_reg_rvalid)
        else $error("read strobe got no answer");
    answer_cause_a: assert property (o_reg_rvalid |-> $past(i_reg.rd))
        else $error("read answer without a read strobe");
    z_low_reserved_a: assert property (o_reg_rvalid && $past(i_reg.addr) == ADDR_STILL_Z_LOW |->
        o_reg_rdata[4:1] == 4'h0) else $error("z low reserved bits not zero");
    y_low_reserved_a: assert property (o_reg_rvalid && $past(i_reg.addr) == ADDR_WARN_Y_LOW |->
        o_reg_rdata[4:1] == 4'h0) else $error("y low reserved bits not zero");
    x_low_reserved_a: assert property (o_reg_rvalid && $past(i_reg.addr) == ADDR_WARN_X_LOW |->
        o_reg_rdata[4:2] == 3'h0) else $error("x low reserved bits not zero");
    unmapped_zero_a: assert property (o_reg_rvalid && ($past(i_reg.addr) < 8'h2F || $past(i_reg.addr) > 8'h35)
        |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    warn_cause_a: assert property (o_warn_pulse |-> $past(i_sample.valid) && o_warn_axes != 3'h0)
        else $error("warning without sample or axis");
    still_cause_a: assert property (o_still_pulse |-> $past(i_sample.valid) && o_still_active)
        else $error("stillness pulse without sample or state");
    timer_restart_a: assert property (i_reg.wr && (i_reg.addr == 8'h30 || i_reg.addr == 8'h31) |=>
        o_still_duration_count == 16'h0 && !o_still_active) else $error("timer write did not restart");
    count_step_a: assert property (o_still_duration_count != $past(o_still_duration_count) |->
        o_still_duration_count == $past(o_still_duration_count) + 16'h1 || o_still_duration_count == 16'h0)
        else $error("duration count jumped");
    warn_seen_c: cover property (o_warn_pulse);
    still_seen_c: cover property (o_still_pulse);
    read_seen_c: cover property (o_reg_rvalid);
endmodule
bind imw_detect imw_detect_props #(.P_CODE_CYC_SLOW(P_CODE_CYC_SLOW), .P_CODE_CYC_FAST(P_CODE_CYC_FAST)) u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_sample(i_sample), .o_still_pulse(o_still_pulse), .o_still_active(o_still_active),
    .o_still_duration_count(o_still_duration_count), .o_warn_pulse(o_warn_pulse), .o_warn_axes(o_warn_axes));

// file: tb/imw_detect_test.sv
// Self-checking bench for the stillness and motion warning detector.
// Assumes short code counts (8 and 4 cycles) so timer runs stay brief.
`timescale 1ns/1ps
module imw_detect_test;
    import imw_pkg::*;
    localparam int P_SLOW = 8;
    localparam int P_FAST = 4;
    logic clk, rst, rate_fast, rvalid, still_pulse, still_active, warn_pulse, rd_ok, got_warn, got_still;
    logic [7:0] rdata, rd_val, a, v;
    logic [15:0] still_count;
    logic [2:0] warn_axes, got_axes, exp_axes;
    logic [10:0] thr, ty;
    logic [1:0] en;
    logic signed [11:0] x, y;
    imw_reg_req_t reg_req;
    imw_sample_t smp;
    imw_ext_cfg_t ext;
    int miscompares, cmp_count, cycles;
    imw_host u_host (.i_clk(clk), .o_reg(reg_req), .i_rdata(rdata), .i_rvalid(rvalid));
    imw_detect #(.P_CODE_CYC_SLOW(P_SLOW), .P_CODE_CYC_FAST(P_FAST)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_reg(reg_req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_sample(smp), .i_rate_fast(rate_fast), .i_ext_cfg(ext), .o_still_pulse(still_pulse),
        .o_still_active(still_active), .o_still_duration_count(still_count), .o_warn_pulse(warn_pulse),
        .o_warn_axes(warn_axes));
    // ==================================================================
    // Helpers
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic send(input logic signed [11:0] sx, input logic signed [11:0] sy, input logic signed [11:0] sz);
        @(posedge clk);
        smp <= '{valid: 1'b1, x: sx, y: sy, z: sz};
        @(posedge clk);
        smp.valid <= 1'b0;
        #1;
        got_warn = warn_pulse;
        got_axes = warn_axes;
        got_still = still_pulse;
    endtask
    function automatic logic [11:0] mag(input logic signed [11:0] s);
        return (s < 0) ? 12'(-s) : 12'(s);
    endfunction
    function automatic logic [7:0] rmask(input logic [7:0] ad);
        if (ad == ADDR_STILL_Z_LOW || ad == ADDR_WARN_Y_LOW) return 8'hE1;
        if (ad == ADDR_WARN_X_LOW) return 8'hE3;
        return (ad > 8'h2F && ad < 8'h35) ? 8'hFF : 8'h00;
    endfunction
    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hB10B780A));
        rst = 1'b1;
        rate_fast = 1'b0;
        smp = '0;
        ext = '{x_still_thr: 11'h7FF, x_still_en: 1'b1, y_still_thr: 11'h7FF, y_still_en: 1'b1,
            z_still_thr_high: 8'h02, z_warn_thr: 11'h7FF, z_warn_en: 1'b1};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            u_host.rd_reg(8'h2F + 8'(i), rd_val, rd_ok);
            chk(rd_val, 8'h00);
            chk(rd_ok, 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            a = 8'h2F + 8'(i);
            v = 8'($urandom);
            u_host.wr_reg(a, v);
            u_host.rd_reg(a, rd_val, rd_ok);
            chk(rd_val, v & rmask(a));
        end
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            thr = 11'($urandom_range(1000));
            ty = 11'($urandom_range(1000));
            en = 2'($urandom);
            x = $signed(12'(thr) + 12'($urandom_range(2)) - 12'h001);
            y = $signed(12'(ty) + 12'($urandom_range(2)) - 12'h001);
            if ($urandom_range(1) == 1) x = -x;
            if ($urandom_range(1) == 1) y = -y;
            u_host.wr_reg(ADDR_WARN_X_HIGH, thr[10:3]);
            u_host.wr_reg(ADDR_WARN_X_LOW, {thr[2:0], 4'h0, en[0]});
            u_host.wr_reg(ADDR_WARN_Y_HIGH, ty[10:3]);
            u_host.wr_reg(ADDR_WARN_Y_LOW, {ty[2:0], 4'h0, en[1]});
            send(x, y, 12'sh000);
            exp_axes = {1'b0, en[1] && mag(y) > 12'(ty), en[0] && mag(x) > 12'(thr)};
            chk(got_axes, exp_axes);
            chk(got_warn, |exp_axes);
        end
        $display("test absolute warning done");
        // Threshold 10 in referenced mode; the first sample only sets the baseline.
        u_host.wr_reg(ADDR_WARN_Y_LOW, 8'h00);
        u_host.wr_reg(ADDR_WARN_X_HIGH, 8'h01);
        u_host.wr_reg(ADDR_WARN_X_LOW, 8'h43);
        x = 12'sh100;
        send(x, 12'sh000, 12'sh000);
        chk(got_warn, 1'b0);
        send(x + 12'sh00A, 12'sh000, 12'sh000);
        chk(got_warn, 1'b0);
        send(x + 12'sh00B, 12'sh000, 12'sh000);
        chk(got_warn, 1'b1);
        send(x + 12'sh00B, 12'sh000, 12'sh000);
        chk(got_warn, 1'b0);
        send(x - 12'sh001, 12'sh000, 12'sh000);
        chk(got_axes, 3'h1);
        $display("test referenced warning done");
        // Z stillness threshold 21 with a duration of two codes.
        u_host.wr_reg(ADDR_STILL_Z_LOW, 8'hA1);
        u_host.wr_reg(ADDR_STILL_TIMER_HIGH, 8'h00);
        u_host.wr_reg(ADDR_STILL_TIMER_LOW, 8'h02);
        send(12'sh000, 12'sh000, 12'sh014);
        chk(got_still, 1'b0);
        repeat (3 * P_SLOW + P_SLOW / 2) @(posedge clk);
        #1;
        chk(still_count, 16'h0003);
        send(12'sh000, 12'sh000, -12'sh014);
        chk(got_still, 1'b1);
        chk(still_active, 1'b1);
        send(12'sh005, -12'sh005, 12'sh015);
        chk(still_active, 1'b0);
        @(posedge clk);
        #1;
        chk(still_count, 16'h0000);
        @(posedge clk);
        rate_fast <= 1'b1;
        u_host.wr_reg(ADDR_STILL_TIMER_LOW, 8'h02);
        repeat (3 * P_FAST + P_FAST / 2) @(posedge clk);
        #1;
        chk(still_count, 16'h0003);
        u_host.wr_reg(ADDR_STILL_TIMER_HIGH, 8'h01);
        repeat (3 * P_FAST + P_FAST / 2) @(posedge clk);
        send(12'sh000, 12'sh000, 12'sh000);
        chk(got_still, 1'b0);
        $display("test stillness done");
        // Mid-run reset: the z enable falls back to off, so a large z no longer breaks stillness.
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        u_host.rd_reg(ADDR_STILL_Z_LOW, rd_val, rd_ok);
        chk(rd_val, 8'h00);
        chk(rd_ok, 1'b1);
        send(12'sh000, 12'sh000, 12'sh7FF);
        chk(got_still, 1'b0);
        send(12'sh000, 12'sh000, 12'sh7FF);
        chk(got_still, 1'b1);
        chk(still_active, 1'b1);
        // An x sample at its own stillness threshold ends the still spell.
        @(posedge clk);
        ext.x_still_thr <= 11'h010;
        send(12'sh010, 12'sh000, 12'sh000);
        chk(still_active, 1'b0);
        $display("test reset and axis enables done");
        print_verdict();
    end
endmodule
